/* mod_map.svh */
// Opcode decoder constants: code bases, masks, low-five patterns and single codes.
`ifndef MOD_MAP_SVH
`define MOD_MAP_SVH
`define MOD_REG_MASK 8'hF8
`define MOD_INC_REG 8'h18
`define MOD_EXCHANGE_REG 8'h28
`define MOD_OR_REG 8'h48
`define MOD_AND_REG 8'h58
`define MOD_ADD_REG 8'h68
`define MOD_ADD_CARRY_REG 8'h78
`define MOD_STORE_REG 8'hA8
`define MOD_LOADI_REG 8'hB8
`define MOD_DEC_REG 8'hC8
`define MOD_XOR_REG 8'hD8
`define MOD_DJNZ_REG 8'hE8
`define MOD_LOAD_REG 8'hF8
`define MOD_EXP_MASK 8'hFC
`define MOD_EXP_READ 8'h0C
`define MOD_EXP_WRITE 8'h3C
`define MOD_EXP_OR 8'h8C
`define MOD_EXP_AND 8'h9C
`define MOD_LOW5_MASK 8'h1F
`define MOD_JMP_PAT 8'h04
`define MOD_CALL_PAT 8'h14
`define MOD_ACC_BIT_PAT 8'h12
`define MOD_NOP 8'h00
`define MOD_HALT 8'h01
`define MOD_OUT_BUS 8'h02
`define MOD_ADD_IMM 8'h03
`define MOD_READ_TMR 8'h42
`define MOD_OR_IMM 8'h43
`define MOD_CNT_START 8'h45
`define MOD_TMR_START 8'h55
`define MOD_JT1 8'h56
`define MOD_DEC_ADJ 8'h57
`define MOD_XMEM_WR0 8'h90
`define MOD_XMEM_WR1 8'h91
`define MOD_RET_RESTORE 8'h93
`endif

/* mod_pkg.sv */
// Types shared by the opcode decoder files.
`default_nettype none
package mod_pkg;
  typedef enum logic [5:0] {
    MOD_OP_NOP, MOD_OP_HALT, MOD_OP_LATCH_OUTPUT, MOD_OP_ADD_IMM, MOD_OP_INC_REG,
    MOD_OP_EXCHANGE_ACC_REG, MOD_OP_OR_INTO_ACC, MOD_OP_AND_INTO_ACC, MOD_OP_ADD_REG,
    MOD_OP_ADD_WITH_CARRY, MOD_OP_XOR_INTO_ACC, MOD_OP_LOAD_ACC, MOD_OP_STORE_ACC,
    MOD_OP_LOAD_IMM_REG, MOD_OP_DEC_REG, MOD_OP_DJNZ, MOD_OP_EXP_READ, MOD_OP_EXP_WRITE,
    MOD_OP_EXPANDER_OR, MOD_OP_EXPANDER_AND, MOD_OP_JUMP, MOD_OP_CALL,
    MOD_OP_BRANCH_ON_ACC_BIT, MOD_OP_READ_TIMER, MOD_OP_OR_IMM, MOD_OP_COUNT_EVENTS_BEGIN,
    MOD_OP_TIMER_BEGIN, MOD_OP_BRANCH_T1, MOD_OP_DECIMAL_ADJUST,
    MOD_OP_RETURN_RESTORE_STATUS, MOD_OP_EXTERNAL_DATA_MOVE_WR, MOD_OP_OTHER
  } mod_op_t;
  typedef enum logic [1:0] {MOD_FMT_1B1C, MOD_FMT_1B2C, MOD_FMT_2B2C} mod_fmt_t;
  // One decoded instruction as handed to the execution datapath.
  typedef struct packed {
    mod_op_t op;
    mod_fmt_t fmt;
    logic [2:0] working_reg_select;
    logic [1:0] expander_port;
    logic [2:0] acc_bit;
    logic indirect_r1;
    logic [11:0] target;
    logic [7:0] immediate;
  } mod_dec_t;
endpackage : mod_pkg
`default_nettype wire

/* mod_classify.sv */
// Combinational classifier for one first instruction byte.
`timescale 1ns/100ps
`default_nettype none
`include "mod_map.svh"
module mod_classify
  import mod_pkg::*;
(
  // Code in.
  input wire logic [7:0] code,
  // Class out.
  output var mod_op_t op,
  output var mod_fmt_t fmt
);
  // Map lookup by row and column.
  always_comb begin
    op = MOD_OP_OTHER;
    fmt = MOD_FMT_1B1C;
    // [RQ11] jump pattern.
    if ((code & `MOD_LOW5_MASK) == `MOD_JMP_PAT) begin
      op = MOD_OP_JUMP;
    // [RQ12] call pattern.
    end else if ((code & `MOD_LOW5_MASK) == `MOD_CALL_PAT) begin
      op = MOD_OP_CALL;
    // [RQ13] accumulator bit test.
    end else if ((code & `MOD_LOW5_MASK) == `MOD_ACC_BIT_PAT) begin
      op = MOD_OP_BRANCH_ON_ACC_BIT;
    end else begin
      // [RQ1] register forms by row.
      case (code & `MOD_REG_MASK)
        `MOD_INC_REG: op = MOD_OP_INC_REG;
        // [RQ2] exchange.
        `MOD_EXCHANGE_REG: op = MOD_OP_EXCHANGE_ACC_REG;
        // [RQ3] or.
        `MOD_OR_REG: op = MOD_OP_OR_INTO_ACC;
        // [RQ4] and.
        `MOD_AND_REG: op = MOD_OP_AND_INTO_ACC;
        // [RQ5] add.
        `MOD_ADD_REG: op = MOD_OP_ADD_REG;
        // [RQ6] add carry.
        `MOD_ADD_CARRY_REG: op = MOD_OP_ADD_WITH_CARRY;
        // [RQ9] store to register.
        `MOD_STORE_REG: op = MOD_OP_STORE_ACC;
        `MOD_LOADI_REG: op = MOD_OP_LOAD_IMM_REG;
        `MOD_DEC_REG: op = MOD_OP_DEC_REG;
        // [RQ7] xor.
        `MOD_XOR_REG: op = MOD_OP_XOR_INTO_ACC;
        `MOD_DJNZ_REG: op = MOD_OP_DJNZ;
        // [RQ8] load from register.
        `MOD_LOAD_REG: op = MOD_OP_LOAD_ACC;
        default: op = MOD_OP_OTHER;
      endcase
      // [RQ10] expander forms.
      case (code & `MOD_EXP_MASK)
        `MOD_EXP_READ: op = MOD_OP_EXP_READ;
        `MOD_EXP_WRITE: op = MOD_OP_EXP_WRITE;
        `MOD_EXP_OR: op = MOD_OP_EXPANDER_OR;
        `MOD_EXP_AND: op = MOD_OP_EXPANDER_AND;
        default: ;
      endcase
      // [RQ16] row zero singles; [RQ17] row four; [RQ18] row five; [RQ19] row nine.
      case (code)
        `MOD_NOP: op = MOD_OP_NOP;
        `MOD_HALT: op = MOD_OP_HALT;
        `MOD_OUT_BUS: op = MOD_OP_LATCH_OUTPUT;
        `MOD_ADD_IMM: op = MOD_OP_ADD_IMM;
        `MOD_READ_TMR: op = MOD_OP_READ_TIMER;
        `MOD_OR_IMM: op = MOD_OP_OR_IMM;
        `MOD_CNT_START: op = MOD_OP_COUNT_EVENTS_BEGIN;
        `MOD_TMR_START: op = MOD_OP_TIMER_BEGIN;
        `MOD_JT1: op = MOD_OP_BRANCH_T1;
        `MOD_DEC_ADJ: op = MOD_OP_DECIMAL_ADJUST;
        `MOD_RET_RESTORE: op = MOD_OP_RETURN_RESTORE_STATUS;
        `MOD_XMEM_WR0, `MOD_XMEM_WR1: op = MOD_OP_EXTERNAL_DATA_MOVE_WR;
        default: ;
      endcase
    end
    // [RQ15] format class from the map shading.
    case (code[3:0])
      4'h3, 4'h6: fmt = (code == 8'hA3 || code == 8'hB3 || code == 8'hE3 || code == 8'h83 ||
                         code == 8'h93) ? MOD_FMT_1B2C :
                        (code[3:0] == 4'h3 && (code == 8'h73 || code == 8'h63 || code == 8'h33 ||
                         code == 8'hC3 || code == 8'hF3)) ? MOD_FMT_1B1C : MOD_FMT_2B2C;
      4'h2: fmt = (code[4] || code == 8'h02) ? ((code == 8'h02) ? MOD_FMT_1B2C : MOD_FMT_2B2C)
                  : MOD_FMT_1B1C;
      4'h4: fmt = MOD_FMT_2B2C;
      4'h8, 4'h9, 4'hA, 4'hB: fmt = (code[7:4] == 4'h0 || code[7:4] == 4'h3) ? MOD_FMT_1B2C :
                  (code[7:4] == 4'h8 || code[7:4] == 4'h9 || code[7:4] == 4'hB ||
                   code[7:4] == 4'hE) ? MOD_FMT_2B2C : MOD_FMT_1B1C;
      4'hC, 4'hD, 4'hE, 4'hF: fmt = (code[7:4] == 4'h0 || code[7:4] == 4'h3 ||
                  code[7:4] == 4'h8 || code[7:4] == 4'h9) ? MOD_FMT_1B2C :
                  (code[7:4] == 4'hB || code[7:4] == 4'hE) ? MOD_FMT_2B2C : MOD_FMT_1B1C;
      4'h0, 4'h1: fmt = (code[7:4] == 4'h8 || code[7:4] == 4'h9) ? MOD_FMT_1B2C :
                  (code[7:4] == 4'hB) ? MOD_FMT_2B2C : MOD_FMT_1B1C;
      default: fmt = MOD_FMT_1B1C;
    endcase
    // [RQ20] blank codes act as one-cycle nops.
    if (op == MOD_OP_OTHER && (code == 8'h06 || code == 8'h22 || code == 8'h33 ||
        code == 8'h38 || code == 8'h3B || code == 8'h63 || code == 8'h66 || code == 8'h73 ||
        code == 8'h82 || code == 8'h87 || code == 8'h8B || code == 8'h9B || code == 8'hA2 ||
        code == 8'hA6 || code == 8'hB7 || code[7:1] == 7'h60 || code == 8'hC2 || code == 8'hC3 ||
        code == 8'hD6 || code[7:1] == 7'h70 || code == 8'hE2 || code == 8'hF3 || code == 8'h0B)) begin
      op = MOD_OP_NOP;
      fmt = MOD_FMT_1B1C;
    end
  end
endmodule : mod_classify
`default_nettype wire

/* mod_opcode_decoder.sv */
// Registered opcode decoder between fetch and execute.
`timescale 1ns/100ps
`default_nettype none
`include "mod_map.svh"
// What this block does
// [RQ1] Register index from opcode bits two..zero.
// [RQ2] Codes 28..2F exchange accumulator with register.
// [RQ3] Codes 48..4F OR register into accumulator.
// [RQ4] Codes 58..5F AND register into accumulator.
// [RQ5] Codes 68..6F add register, no carry.
// [RQ6] Codes 78..7F add register plus carry.
// [RQ7] Codes D8..DF XOR register into accumulator.
// [RQ8] Codes F8..FF copy register to accumulator.
// [RQ9] Codes A8..AF store accumulator to register.
// [RQ10] Expander port from bits one..zero.
// [RQ11] Jump: low five 00100, high target bits.
// [RQ12] Call: low five 10100, high target bits.
// [RQ13] Bit branch: low five 10010, bit number.
// [RQ14] Row/column map; immediates from next byte.
// [RQ15] Every code classed by bytes and cycles.
// [RQ16] Row zero: nop, halt, output, add-immediate.
// [RQ17] Row four: timer read, counting, OR-immediate.
// [RQ18] Row five: timer start, T1 branch, adjust.
// [RQ19] Row nine: restore-return, external writes.
// [RQ20] Blank codes decode as one-cycle nops.
// [RQ21] Target bit eleven from program bank flag.
module mod_opcode_decoder
  import mod_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Fetched bytes from the fetch unit.
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic program_bank_flag,
  // Decoded instruction to the datapath.
  output logic dec_valid,
  output var mod_dec_t dec_out
);
  // Waiting for first or second byte.
  typedef enum logic {MOD_ST_FIRST, MOD_ST_SECOND} mod_state_t;
  mod_state_t state;
  mod_state_t next_state;
  // First byte held while the second arrives.
  logic [7:0] first;
  logic [7:0] next_first;
  logic next_dec_valid;
  mod_dec_t next_dec_out;
  // Classification of the current byte and of the held first byte.
  mod_op_t cls_op;
  mod_fmt_t cls_fmt;
  logic [7:0] cls_code;

  // The classifier looks at the new byte in state one and the held byte in state two.
  assign cls_code = (state == MOD_ST_FIRST) ? byte_data : first;

  mod_classify u_classify (
    .code(cls_code),
    .op(cls_op),
    .fmt(cls_fmt)
  );

  // Next-state logic; two-byte codes wait for their operand byte.
  always_comb begin
    next_state = state;
    next_first = first;
    next_dec_valid = 1'b0;
    next_dec_out = dec_out;
    if (byte_valid) begin
      // [RQ14] row and column lookup.
      next_dec_out.op = cls_op;
      next_dec_out.fmt = cls_fmt;
      // [RQ1] register index field.
      next_dec_out.working_reg_select = cls_code[2:0];
      // [RQ10] expander port field.
      next_dec_out.expander_port = cls_code[1:0];
      // [RQ13] tested accumulator bit.
      next_dec_out.acc_bit = cls_code[7:5];
      next_dec_out.indirect_r1 = cls_code[0];
      if (state == MOD_ST_FIRST) begin
        // [RQ15] two-byte codes never finish alone.
        if (cls_fmt == MOD_FMT_2B2C) begin
          next_first = byte_data;
          next_state = MOD_ST_SECOND;
        end else begin
          next_dec_valid = 1'b1;
          next_dec_out.immediate = 8'h00;
          next_dec_out.target = 12'h000;
        end
      end else begin
        // [RQ14] operand from following byte.
        next_dec_out.immediate = byte_data;
        // [RQ11] target high bits, [RQ21] bank bit eleven.
        next_dec_out.target = (cls_op == MOD_OP_JUMP || cls_op == MOD_OP_CALL) ?
          {program_bank_flag, first[7:5], byte_data} : {4'h0, byte_data};
        next_dec_valid = 1'b1;
        next_state = MOD_ST_FIRST;
      end
    end
  end

  // Registers only; asynchronous reset to idle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= MOD_ST_FIRST;
      first <= 8'h00;
      dec_valid <= 1'b0;
      dec_out <= '0;
    end else begin
      state <= next_state;
      first <= next_first;
      dec_valid <= next_dec_valid;
      dec_out <= next_dec_out;
    end
  end

  // [RQ2] exchange code check.
  AST_EXCHANGE: assert property (@(posedge clk_sys) disable iff (reset) // [RQ2]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h05) |=> dec_valid &&
      dec_out.op == MOD_OP_EXCHANGE_ACC_REG && dec_out.working_reg_select == $past(byte_data[2:0]))
    else $error("exchange decode wrong");
  // [RQ3] or code check.
  AST_OR: assert property (@(posedge clk_sys) disable iff (reset) // [RQ3]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h09) |=> dec_out.op == MOD_OP_OR_INTO_ACC)
    else $error("or decode wrong");
  // [RQ4] and code check.
  AST_AND: assert property (@(posedge clk_sys) disable iff (reset) // [RQ4]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h0B) |=> dec_out.op == MOD_OP_AND_INTO_ACC)
    else $error("and decode wrong");
  // [RQ5] add code check.
  AST_ADD: assert property (@(posedge clk_sys) disable iff (reset) // [RQ5]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h0D) |=> dec_out.op == MOD_OP_ADD_REG)
    else $error("add decode wrong");
  // [RQ6] add carry check.
  AST_ADD_CARRY: assert property (@(posedge clk_sys) disable iff (reset) // [RQ6]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h0F) |=> dec_out.op == MOD_OP_ADD_WITH_CARRY)
    else $error("add carry decode wrong");
  // [RQ7] xor check.
  AST_XOR: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h1B) |=> dec_out.op == MOD_OP_XOR_INTO_ACC)
    else $error("xor decode wrong");
  // [RQ8] load check.
  AST_LOAD: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h1F) |=> dec_out.op == MOD_OP_LOAD_ACC)
    else $error("load decode wrong");
  // [RQ9] store check.
  AST_STORE: assert property (@(posedge clk_sys) disable iff (reset) // [RQ9]
    (state == MOD_ST_FIRST && byte_valid && byte_data[7:3] == 5'h15) |=> dec_out.op == MOD_OP_STORE_ACC)
    else $error("store decode wrong");
  // [RQ11] [RQ21] jump target assembled from both bytes.
  AST_JMP_TARGET: assert property (@(posedge clk_sys) disable iff (reset) // [RQ11]
    (state == MOD_ST_FIRST && byte_valid && byte_data[4:0] == 5'h04) ##1 (byte_valid)
      |=> dec_valid && dec_out.op == MOD_OP_JUMP &&
      dec_out.target == {$past(program_bank_flag), $past(byte_data[7:5], 2), $past(byte_data)})
    else $error("jump target wrong");
  // [RQ15] two-byte code holds output low one byte.
  AST_TWO_BYTE: assert property (@(posedge clk_sys) disable iff (reset) // [RQ15]
    (state == MOD_ST_FIRST && byte_valid && byte_data[4:0] == 5'h14) |=> !dec_valid)
    else $error("two-byte finished early");
endmodule : mod_opcode_decoder
`default_nettype wire

/* mod_fetch_model.sv */
// Fetch-side model that streams instruction bytes into the opcode decoder.
`timescale 1ns/100ps
`default_nettype none
module mod_fetch_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Byte stream towards the decoder.
  output var logic byte_valid,
  output var logic [7:0] byte_data,
  output var logic program_bank_flag
);
  // Program image and bank bit for each byte, filled in by the bench.
  logic [7:0] prog [0:127];
  logic bank [0:127];

  // Idle lines show a changing pattern, so a stale byte never looks fresh.
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'hA5;
    program_bank_flag = 1'b0;
  end

  // Sends n bytes in program order; slow leaves an idle cycle after each byte.
  // bytes in order
  task automatic run(input int n, input bit slow);
    while (reset) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      byte_valid <= 1'b1;
      byte_data <= prog[i];
      program_bank_flag <= bank[i];
      if (slow) begin
        @(posedge clk_sys);
        byte_valid <= 1'b0;
        byte_data <= ~prog[i];
        program_bank_flag <= ~bank[i];
      end
    end
    @(posedge clk_sys);
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
    program_bank_flag <= ~program_bank_flag;
  endtask : run
endmodule : mod_fetch_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the registered opcode decoder.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench
  import mod_pkg::*;
;
  // Clock, reset and the wires between the fetch model and the decoder.
  logic clk_sys;
  logic reset = 1'b1;
  wire byte_valid;
  wire [7:0] byte_data;
  wire program_bank_flag;
  logic dec_valid;
  mod_dec_t dec_out;
  // Counters, captured decodes and expected decodes with a field mask each.
  int n_errors = 0;
  int tests_run = 0;
  int n_exp = 0;
  int n_bytes = 0;
  mod_dec_t got_q[$];
  mod_dec_t exp_d [0:127];
  logic [7:0] mask_d [0:127];
  logic prev_bv = 1'b0;
  // Register-form and expander bases with the operation each one selects.
  logic [7:0] reg_base [0:8] = '{8'h18, 8'h28, 8'h48, 8'h58, 8'h68, 8'h78, 8'hA8, 8'hD8, 8'hF8};
  mod_op_t reg_op [0:8] = '{MOD_OP_INC_REG, MOD_OP_EXCHANGE_ACC_REG, MOD_OP_OR_INTO_ACC, MOD_OP_AND_INTO_ACC,
    MOD_OP_ADD_REG, MOD_OP_ADD_WITH_CARRY, MOD_OP_STORE_ACC, MOD_OP_XOR_INTO_ACC, MOD_OP_LOAD_ACC};
  logic [7:0] exp_base [0:3] = '{8'h0C, 8'h3C, 8'h8C, 8'h9C};
  mod_op_t exp_op [0:3] = '{MOD_OP_EXP_READ, MOD_OP_EXP_WRITE, MOD_OP_EXPANDER_OR, MOD_OP_EXPANDER_AND};
  // Fixed codes of rows 0, 4, 5 and 9, then four blank map codes.
  logic [7:0] one_code [0:16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h42, 8'h43, 8'h45, 8'h55, 8'h56, 8'h57,
    8'h90, 8'h91, 8'h93, 8'h06, 8'h3B, 8'hC0, 8'h63};
  mod_op_t one_op [0:16] = '{MOD_OP_NOP, MOD_OP_HALT, MOD_OP_LATCH_OUTPUT, MOD_OP_ADD_IMM, MOD_OP_READ_TIMER,
    MOD_OP_OR_IMM, MOD_OP_COUNT_EVENTS_BEGIN, MOD_OP_TIMER_BEGIN, MOD_OP_BRANCH_T1, MOD_OP_DECIMAL_ADJUST,
    MOD_OP_EXTERNAL_DATA_MOVE_WR, MOD_OP_EXTERNAL_DATA_MOVE_WR, MOD_OP_RETURN_RESTORE_STATUS,
    MOD_OP_NOP, MOD_OP_NOP, MOD_OP_NOP, MOD_OP_NOP};
  mod_fmt_t one_fmt [0:16] = '{MOD_FMT_1B1C, MOD_FMT_1B1C, MOD_FMT_1B2C, MOD_FMT_2B2C, MOD_FMT_1B1C,
    MOD_FMT_2B2C, MOD_FMT_1B1C, MOD_FMT_1B1C, MOD_FMT_2B2C, MOD_FMT_1B1C, MOD_FMT_1B2C, MOD_FMT_1B2C,
    MOD_FMT_1B2C, MOD_FMT_1B1C, MOD_FMT_1B1C, MOD_FMT_1B1C, MOD_FMT_1B1C};

  mod_fetch_model i_fetch (.clk_sys(clk_sys), .reset(reset), .byte_valid(byte_valid),
    .byte_data(byte_data), .program_bank_flag(program_bank_flag));
  mod_opcode_decoder i_dut (.clk_sys(clk_sys), .reset(reset), .byte_valid(byte_valid),
    .byte_data(byte_data), .program_bank_flag(program_bank_flag), .dec_valid(dec_valid), .dec_out(dec_out));

  // Free-running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Captures every decode; each pulse must follow the edge that took the last byte.
  always @(posedge clk_sys) begin
    if (dec_valid === 1'b1) begin
      got_q.push_back(dec_out);
      `CHK(prev_bv, 1'b1)
    end
    prev_bv <= byte_valid;
  end

  // Queues one instruction; for a two-byte one the bank bit is inverted on the first byte so a wrong sample shows.
  task automatic add(input logic [7:0] b0, input logic [7:0] b1, input bit two, input bit bk,
                     input mod_op_t op, input mod_fmt_t fmt);
    i_fetch.prog[n_bytes] = b0;
    i_fetch.bank[n_bytes] = two ? ~bk : bk;
    n_bytes++;
    if (two) begin
      i_fetch.prog[n_bytes] = b1;
      i_fetch.bank[n_bytes] = bk;
      n_bytes++;
    end
    exp_d[n_exp] = '0;
    exp_d[n_exp].op = op;
    exp_d[n_exp].fmt = fmt;
    exp_d[n_exp].immediate = two ? b1 : 8'h00;
    exp_d[n_exp].target = two ? {4'h0, b1} : 12'h000;
    mask_d[n_exp] = 8'hC3;
    n_exp++;
  endtask : add

  // Streams the queued bytes, then compares every masked field of every decode.
  task automatic play(input string name, input bit slow);
    mod_dec_t g;
    i_fetch.run(n_bytes, slow);
    repeat (3) @(posedge clk_sys);
    `CHK(got_q.size(), n_exp)
    for (int i = 0; i < n_exp && i < got_q.size(); i++) begin
      g = got_q[i];
      if (mask_d[i][7]) `CHK(g.op, exp_d[i].op)
      if (mask_d[i][6]) `CHK(g.fmt, exp_d[i].fmt)
      if (mask_d[i][5]) `CHK(g.working_reg_select, exp_d[i].working_reg_select)
      if (mask_d[i][4]) `CHK(g.expander_port, exp_d[i].expander_port)
      if (mask_d[i][3]) `CHK(g.acc_bit, exp_d[i].acc_bit)
      if (mask_d[i][2]) `CHK(g.indirect_r1, exp_d[i].indirect_r1)
      if (mask_d[i][1]) `CHK(g.target, exp_d[i].target)
      if (mask_d[i][0]) `CHK(g.immediate, exp_d[i].immediate)
    end
    got_q.delete();
    n_exp = 0;
    n_bytes = 0;
    $display("TB: test %s done, mismatches so far %0d", name, n_errors);
  endtask : play

  // register forms, all 96 codes back to back.
  task automatic t_regs();
    for (int k = 0; k < 9; k++) begin
      for (int r = 0; r < 8; r++) begin
        add(reg_base[k] | 8'(r), 8'h00, 1'b0, 1'b0, reg_op[k], MOD_FMT_1B1C);
        exp_d[n_exp - 1].working_reg_select = 3'(r);
        mask_d[n_exp - 1] = 8'hE3;
      end
    end
    // The decrement takes its index from its only byte; the two-byte register forms keep it from the held first byte.
    for (int r = 0; r < 8; r++) begin
      add(8'hC8 | 8'(r), 8'h00, 1'b0, 1'b0, MOD_OP_DEC_REG, MOD_FMT_1B1C);
      exp_d[n_exp - 1].working_reg_select = 3'(r);
      mask_d[n_exp - 1] = 8'hE3;
      add(8'hB8 | 8'(r), 8'h40 + 8'(r), 1'b1, 1'b0, MOD_OP_LOAD_IMM_REG, MOD_FMT_2B2C);
      exp_d[n_exp - 1].working_reg_select = 3'(r);
      mask_d[n_exp - 1] = 8'hE3;
      add(8'hE8 | 8'(r), 8'h60 + 8'(r), 1'b1, 1'b0, MOD_OP_DJNZ, MOD_FMT_2B2C);
      exp_d[n_exp - 1].working_reg_select = 3'(r);
      mask_d[n_exp - 1] = 8'hE3;
    end
    play("register forms", 1'b0);
  endtask : t_regs

  // expander ports, sent with idle cycles between bytes.
  task automatic t_expander();
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 4; p++) begin
        add(exp_base[k] | 8'(p), 8'h00, 1'b0, 1'b0, exp_op[k], MOD_FMT_1B2C);
        exp_d[n_exp - 1].expander_port = 2'(p);
        mask_d[n_exp - 1] = 8'hD3;
      end
    end
    play("expander", 1'b1);
  endtask : t_expander

  // jump, call and bit branch for every high field.
  task automatic t_branch();
    logic [7:0] lo;
    for (int h = 0; h < 8; h++) begin
      lo = 8'h5A + 8'(h);
      add({3'(h), 5'b00100}, lo, 1'b1, h[0], MOD_OP_JUMP, MOD_FMT_2B2C);
      exp_d[n_exp - 1].target = {h[0], 3'(h), lo};
      lo = 8'hA0 + 8'(h);
      add({3'(h), 5'b10100}, lo, 1'b1, ~h[0], MOD_OP_CALL, MOD_FMT_2B2C);
      exp_d[n_exp - 1].target = {~h[0], 3'(h), lo};
      add({3'(h), 5'b10010}, 8'h33 + 8'(h), 1'b1, 1'b1, MOD_OP_BRANCH_ON_ACC_BIT, MOD_FMT_2B2C);
      exp_d[n_exp - 1].acc_bit = 3'(h);
      mask_d[n_exp - 1] = 8'hCB;
    end
    play("branches", 1'b0);
  endtask : t_branch

  // fixed codes and blanks; halt cycle class is left open.
  task automatic t_fixed();
    for (int k = 0; k < 17; k++) begin
      add(one_code[k], 8'hC0 + 8'(k), one_fmt[k] == MOD_FMT_2B2C, 1'b1, one_op[k], one_fmt[k]);
      if (k == 1) mask_d[n_exp - 1] = 8'h83;
      if (k == 10 || k == 11) begin
        exp_d[n_exp - 1].indirect_r1 = (k == 11);
        mask_d[n_exp - 1] = 8'hC7;
      end
    end
    play("fixed codes", 1'b0);
  endtask : t_fixed

  // A reset between the two bytes of a jump must drop the held byte, so the next jump decodes whole.
  task automatic t_reset();
    i_fetch.prog[0] = 8'h24;
    i_fetch.bank[0] = 1'b0;
    i_fetch.run(1, 1'b0);
    reset <= 1'b1;
    @(posedge clk_sys);
    `CHK(dec_valid, 1'b0)
    `CHK(dec_out, '0)
    reset <= 1'b0;
    add(8'h24, 8'h56, 1'b1, 1'b1, MOD_OP_JUMP, MOD_FMT_2B2C);
    exp_d[n_exp - 1].target = 12'h956;
    play("reset mid instruction", 1'b0);
  endtask : t_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("TB: comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #(4 * 5000);
    n_errors++;
    $display("TB: watchdog expired");
    complete_run();
  end

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    repeat (15) @(posedge clk_sys);
    `CHK(dec_valid, 1'b0)
    `CHK(dec_out, '0)
    @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_expander();
    t_branch();
    t_fixed();
    t_reset();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
